// [rom_pkg.sv]
// Constants for the radio observation multiplexer
package rom_pkg;
	localparam int CLK_MHZ = 250;
	localparam int RAND_RATE_MHZ = 8;
	localparam int RAND_UPDATE_CYC = CLK_MHZ / RAND_RATE_MHZ;
	localparam int SNIFF_CLK_KHZ = 250;
	localparam int SNIFF_HALF_CYC = (CLK_MHZ * 1000) / (2 * SNIFF_CLK_KHZ);

	localparam logic [29:0] IDX_OBS_CTRL0 = 30'h0000_61EB;
	localparam logic [29:0] IDX_OBS_CTRL1 = 30'h0000_61EC;
	localparam logic [29:0] IDX_OBS_CTRL2 = 30'h0000_61ED;
	localparam logic [29:0] IDX_RXQ_THRESH = 30'h0000_61EE;
	localparam logic [29:0] IDX_OBS_STATUS = 30'h0000_61EF;

	localparam int CTRL_INVERT_BIT = 6;
	localparam int CTRL_SEL_MSB = 5;
	localparam logic [6:0] CTRL_RESET = 7'h00;
	localparam logic [7:0] THRESH_RESET = 8'h00;

	localparam logic [3:0] FF_RX_LO = 4'h2;
	localparam logic [3:0] FF_RX_HI = 4'h7;
	localparam logic [3:0] FF_TX_LO = 4'h8;
	localparam logic [3:0] FF_TX_HI = 4'hB;

	localparam logic [5:0] SEL_ZERO = 6'h00;
	localparam logic [5:0] SEL_ONE = 6'h01;
	localparam logic [5:0] SEL_SNIFF_DATA = 6'h08;
	localparam logic [5:0] SEL_SNIFF_CLK = 6'h09;
	localparam logic [5:0] SEL_RSSI_VALID = 6'h0C;
	localparam logic [5:0] SEL_SFD_SYNC = 6'h0F;
	localparam logic [5:0] SEL_TX_STATE = 6'h10;
	localparam logic [5:0] SEL_RX_STATE = 6'h11;
	localparam logic [5:0] SEL_RXQ_NONEMPTY = 6'h12;
	localparam logic [5:0] SEL_RXQ_LEVEL = 6'h13;
	localparam logic [5:0] SEL_PKT_DONE = 6'h14;
	localparam logic [5:0] SEL_RAND_XOR = 6'h16;
	localparam logic [5:0] SEL_RAND_Q = 6'h17;
	localparam logic [5:0] SEL_RAND_I = 6'h18;
	localparam logic [5:0] SEL_LOCK = 6'h19;
	localparam logic [5:0] SEL_AMP_PD = 6'h28;
	localparam logic [5:0] SEL_LNA_PD = 6'h2A;

	// Bit positions in the source vector
	localparam int SRC_SNIFF_DATA = 0;
	localparam int SRC_SNIFF_CLK = 1;
	localparam int SRC_RSSI_VALID = 2;
	localparam int SRC_SFD_SYNC = 3;
	localparam int SRC_TX_STATE = 4;
	localparam int SRC_RX_STATE = 5;
	localparam int SRC_RXQ_NONEMPTY = 6;
	localparam int SRC_RXQ_LEVEL = 7;
	localparam int SRC_PKT_DONE = 8;
	localparam int SRC_RAND_XOR = 9;
	localparam int SRC_RAND_Q = 10;
	localparam int SRC_RAND_I = 11;
	localparam int SRC_LOCK = 12;
	localparam int SRC_AMP_PD = 13;
	localparam int SRC_LNA_PD = 14;
	localparam int SRC_COUNT = 15;
endpackage : rom_pkg

// [rom_if.sv]
// Carriers between the observation mux modules
`timescale 1ns/1ns
`default_nettype none
interface rom_src_if;
	logic [rom_pkg::SRC_COUNT-1:0] src;
	modport prod (output src);
	modport cons (input src);
endinterface : rom_src_if

interface rom_reg_if;
	logic wr_stb;
	logic [29:0] idx;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport bus (output wr_stb, output idx, output wdata, input rdata);
	modport regs (input wr_stb, input idx, input wdata, output rdata);
endinterface : rom_reg_if
`default_nettype wire

// [rom_obs_chan.sv]
// One observation channel: select decode and polarity
`timescale 1ns/1ns
`default_nettype none
module rom_obs_chan (
	input wire logic [5:0] select_i,
	input wire logic invert_i,
	rom_src_if.cons src_bus,
	output logic obs_o
);
	logic picked;

	// Left unregistered so state flags reach the pin as decoded
	always_comb begin
		case (select_i)
			rom_pkg::SEL_ZERO: picked = 1'b0;
			rom_pkg::SEL_ONE: picked = 1'b1;
			rom_pkg::SEL_SNIFF_DATA: picked = src_bus.src[rom_pkg::SRC_SNIFF_DATA];
			rom_pkg::SEL_SNIFF_CLK: picked = src_bus.src[rom_pkg::SRC_SNIFF_CLK];
			rom_pkg::SEL_RSSI_VALID: picked = src_bus.src[rom_pkg::SRC_RSSI_VALID];
			rom_pkg::SEL_SFD_SYNC: picked = src_bus.src[rom_pkg::SRC_SFD_SYNC];
			rom_pkg::SEL_TX_STATE: picked = src_bus.src[rom_pkg::SRC_TX_STATE];
			rom_pkg::SEL_RX_STATE: picked = src_bus.src[rom_pkg::SRC_RX_STATE];
			rom_pkg::SEL_RXQ_NONEMPTY: picked = src_bus.src[rom_pkg::SRC_RXQ_NONEMPTY];
			rom_pkg::SEL_RXQ_LEVEL: picked = src_bus.src[rom_pkg::SRC_RXQ_LEVEL];
			rom_pkg::SEL_PKT_DONE: picked = src_bus.src[rom_pkg::SRC_PKT_DONE];
			rom_pkg::SEL_RAND_XOR: picked = src_bus.src[rom_pkg::SRC_RAND_XOR];
			rom_pkg::SEL_RAND_Q: picked = src_bus.src[rom_pkg::SRC_RAND_Q];
			rom_pkg::SEL_RAND_I: picked = src_bus.src[rom_pkg::SRC_RAND_I];
			rom_pkg::SEL_LOCK: picked = src_bus.src[rom_pkg::SRC_LOCK];
			rom_pkg::SEL_AMP_PD: picked = src_bus.src[rom_pkg::SRC_AMP_PD];
			rom_pkg::SEL_LNA_PD: picked = src_bus.src[rom_pkg::SRC_LNA_PD];
			default: picked = 1'b0;
		endcase
	end

	assign obs_o = picked ^ invert_i;
endmodule : rom_obs_chan
`default_nettype wire

// [rom_ahb_slave.sv]
// AHB-Lite slave front end for the observation registers
`timescale 1ns/1ns
`default_nettype none
module rom_ahb_slave (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	rom_reg_if.bus reg_bus
);
	logic wr_pend_reg;
	logic rd_pend_reg;
	logic rd_wait_reg;
	logic [29:0] idx_reg;
	logic [31:0] hrdata_reg;
	logic accept;

	// Only NONSEQ/SEQ word transfers act; narrower sizes are ignored
	assign accept = hsel_i && hready_i && htrans_i[1] && (hsize_i == 3'h2);

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			idx_reg <= 30'h0000_0000;
		end else if (hready_i || !hreadyout_o) begin
			if (hreadyout_o) begin
				wr_pend_reg <= accept && hwrite_i;
				rd_pend_reg <= accept && !hwrite_i;
				if (accept) begin
					idx_reg <= haddr_i[31:2];
				end
			end else begin
				rd_pend_reg <= 1'b0;
			end
		end
	end

	// One wait state on reads so the data leaves a flip-flop
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rd_wait_reg <= 1'b0;
			hrdata_reg <= 32'h0000_0000;
		end else begin
			rd_wait_reg <= rd_pend_reg && !rd_wait_reg;
			if (rd_pend_reg && !rd_wait_reg) begin
				hrdata_reg <= {24'h00_0000, reg_bus.rdata};
			end
		end
	end

	assign hreadyout_o = !(rd_pend_reg && !rd_wait_reg);
	assign hresp_o = 1'b0;
	assign hrdata_o = hrdata_reg;
	assign reg_bus.idx = idx_reg;
	assign reg_bus.wr_stb = wr_pend_reg;
	assign reg_bus.wdata = hwdata_i[7:0];
endmodule : rom_ahb_slave
`default_nettype wire

// [rom_top.sv]
// Radio observation multiplexer: registers, signal sources and three channels
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module rom_top #(
	parameter int RXQ_COUNT_W = 8
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	// AHB-Lite register port
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	// Radio core status, same clock
	input wire logic radio_rx_on_i,
	input wire logic radio_tx_on_i,
	input wire logic sfd_seen_i,
	input wire logic rssi_update_i,
	input wire logic [3:0] ffctrl_state_i,
	input wire logic [RXQ_COUNT_W-1:0] receive_queue_count_i,
	input wire logic receive_queue_overflow_i,
	input wire logic receive_queue_frame_i,
	input wire logic packet_done_i,
	input wire logic rand_i_i,
	input wire logic rand_q_i,
	input wire logic sniff_data_i,
	input wire logic amp_powerdown_i,
	input wire logic lownoise_amp_powerdown_i,
	// Analog lock detector, asynchronous
	input wire logic synth_lock_i,
	// Observation pins
	output logic [2:0] obs_o
);
	//////////////////////////////////////////////////////////////////////////
	// Register interface
	rom_reg_if reg_bus ();
	rom_src_if src_bus ();

	rom_ahb_slave u_ahb (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.hsel_i(hsel_i),
		.haddr_i(haddr_i),
		.htrans_i(htrans_i),
		.hwrite_i(hwrite_i),
		.hsize_i(hsize_i),
		.hwdata_i(hwdata_i),
		.hready_i(hready_i),
		.hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o),
		.hrdata_o(hrdata_o),
		.reg_bus(reg_bus)
	);

	// Bit 7 is not stored at all, so it cannot read back as one
	logic [6:0] ctrl_reg [3];
	logic [7:0] thresh_reg;
	logic [7:0] status_word;

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_reg[0] <= rom_pkg::CTRL_RESET;
			ctrl_reg[1] <= rom_pkg::CTRL_RESET;
			ctrl_reg[2] <= rom_pkg::CTRL_RESET;
		end else if (reg_bus.wr_stb) begin
			case (reg_bus.idx)
				rom_pkg::IDX_OBS_CTRL0: ctrl_reg[0] <= reg_bus.wdata[6:0];
				rom_pkg::IDX_OBS_CTRL1: ctrl_reg[1] <= reg_bus.wdata[6:0];
				rom_pkg::IDX_OBS_CTRL2: ctrl_reg[2] <= reg_bus.wdata[6:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			thresh_reg <= rom_pkg::THRESH_RESET;
		end else if (reg_bus.wr_stb && reg_bus.idx == rom_pkg::IDX_RXQ_THRESH) begin
			thresh_reg <= reg_bus.wdata;
		end
	end

	always_comb begin
		case (reg_bus.idx)
			rom_pkg::IDX_OBS_CTRL0: reg_bus.rdata = {1'b0, ctrl_reg[0]};
			rom_pkg::IDX_OBS_CTRL1: reg_bus.rdata = {1'b0, ctrl_reg[1]};
			rom_pkg::IDX_OBS_CTRL2: reg_bus.rdata = {1'b0, ctrl_reg[2]};
			rom_pkg::IDX_RXQ_THRESH: reg_bus.rdata = thresh_reg;
			rom_pkg::IDX_OBS_STATUS: reg_bus.rdata = status_word;
			default: reg_bus.rdata = 8'h00;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// Lock detector crossing
	logic lock_meta_reg;
	logic lock_sync_reg;

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			lock_meta_reg <= 1'b0;
			lock_sync_reg <= 1'b0;
		end else begin
			lock_meta_reg <= synth_lock_i;
			lock_sync_reg <= lock_meta_reg;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Frame delimiter and signal strength flags
	logic sfd_rx_reg;
	logic sfd_tx_reg;
	logic rssi_valid_reg;

	// A delimiter in the cycle the radio stays on sets the flag; leaving clears it
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sfd_rx_reg <= 1'b0;
			sfd_tx_reg <= 1'b0;
		end else begin
			sfd_rx_reg <= radio_rx_on_i && (sfd_rx_reg || sfd_seen_i);
			sfd_tx_reg <= radio_tx_on_i && (sfd_tx_reg || sfd_seen_i);
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rssi_valid_reg <= 1'b0;
		end else begin
			rssi_valid_reg <= radio_rx_on_i && (rssi_valid_reg || rssi_update_i);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Queue controller decode, deliberately unregistered
	logic tx_state;
	logic rx_state;

	assign tx_state = (ffctrl_state_i >= rom_pkg::FF_TX_LO)
		&& (ffctrl_state_i <= rom_pkg::FF_TX_HI);
	assign rx_state = (ffctrl_state_i >= rom_pkg::FF_RX_LO)
		&& (ffctrl_state_i <= rom_pkg::FF_RX_HI);

	//////////////////////////////////////////////////////////////////////////
	// Receive queue level flags
	logic rxq_nonempty;
	logic rxq_level;

	assign rxq_nonempty = (receive_queue_count_i != '0) && !receive_queue_overflow_i;
	assign rxq_level = (receive_queue_count_i > RXQ_COUNT_W'(thresh_reg))
		|| receive_queue_frame_i || receive_queue_overflow_i;

	//////////////////////////////////////////////////////////////////////////
	// Random bits held at the 8 MHz update rate
	logic [4:0] rand_cnt_reg;
	logic rand_i_reg;
	logic rand_q_reg;

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rand_cnt_reg <= 5'h00;
		end else if (rand_cnt_reg == 5'(rom_pkg::RAND_UPDATE_CYC - 1)) begin
			rand_cnt_reg <= 5'h00;
		end else begin
			rand_cnt_reg <= rand_cnt_reg + 5'h01;
		end
	end

	// 250/8 is not whole; the update period rounds down to 31 cycles
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rand_i_reg <= 1'b0;
			rand_q_reg <= 1'b0;
		end else if (rand_cnt_reg == 5'h00) begin
			rand_i_reg <= rand_i_i;
			rand_q_reg <= rand_q_i;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Packet sniffer clock and data
	logic [9:0] sniff_cnt_reg;
	logic sniff_clk_reg;
	logic sniff_data_reg;
	logic sniff_half;

	assign sniff_half = (sniff_cnt_reg == 10'(rom_pkg::SNIFF_HALF_CYC - 1));

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sniff_cnt_reg <= 10'h000;
			sniff_clk_reg <= 1'b0;
		end else if (sniff_half) begin
			sniff_cnt_reg <= 10'h000;
			sniff_clk_reg <= !sniff_clk_reg;
		end else begin
			sniff_cnt_reg <= sniff_cnt_reg + 10'h001;
		end
	end

	// Data changes on the falling edge so it is steady at the rising one
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sniff_data_reg <= 1'b0;
		end else if (sniff_half && sniff_clk_reg) begin
			sniff_data_reg <= sniff_data_i;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Source vector and channels
	always_comb begin
		src_bus.src = '0;
		src_bus.src[rom_pkg::SRC_SNIFF_DATA] = sniff_data_reg;
		src_bus.src[rom_pkg::SRC_SNIFF_CLK] = sniff_clk_reg;
		src_bus.src[rom_pkg::SRC_RSSI_VALID] = rssi_valid_reg;
		src_bus.src[rom_pkg::SRC_SFD_SYNC] = sfd_rx_reg || sfd_tx_reg;
		src_bus.src[rom_pkg::SRC_TX_STATE] = tx_state;
		src_bus.src[rom_pkg::SRC_RX_STATE] = rx_state;
		src_bus.src[rom_pkg::SRC_RXQ_NONEMPTY] = rxq_nonempty;
		src_bus.src[rom_pkg::SRC_RXQ_LEVEL] = rxq_level;
		src_bus.src[rom_pkg::SRC_PKT_DONE] = packet_done_i;
		src_bus.src[rom_pkg::SRC_RAND_XOR] = rand_i_reg ^ rand_q_reg;
		src_bus.src[rom_pkg::SRC_RAND_Q] = rand_q_reg;
		src_bus.src[rom_pkg::SRC_RAND_I] = rand_i_reg;
		src_bus.src[rom_pkg::SRC_LOCK] = lock_sync_reg;
		src_bus.src[rom_pkg::SRC_AMP_PD] = amp_powerdown_i;
		src_bus.src[rom_pkg::SRC_LNA_PD] = lownoise_amp_powerdown_i;
	end

	genvar ch;
	generate
		for (ch = 0; ch < 3; ch++) begin : g_chan
			rom_obs_chan u_chan (
				.select_i(ctrl_reg[ch][rom_pkg::CTRL_SEL_MSB:0]),
				.invert_i(ctrl_reg[ch][rom_pkg::CTRL_INVERT_BIT]),
				.src_bus(src_bus),
				.obs_o(obs_o[ch])
			);
		end
	endgenerate

	assign status_word = {lock_sync_reg, rxq_level, rxq_nonempty, rx_state, tx_state, obs_o};
endmodule : rom_top
`default_nettype wire

// [rom_top_asserts.sv]
// Concurrent checks on the observation multiplexer top ports
`timescale 1ns/1ns
`default_nettype none
module rom_top_asserts #(
	parameter int RXQ_COUNT_W = 8
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic [31:0] hrdata_o,
	input wire logic radio_rx_on_i,
	input wire logic radio_tx_on_i,
	input wire logic sfd_seen_i,
	input wire logic [3:0] ffctrl_state_i,
	input wire logic [RXQ_COUNT_W-1:0] receive_queue_count_i,
	input wire logic receive_queue_overflow_i,
	input wire logic receive_queue_frame_i,
	input wire logic packet_done_i,
	input wire logic amp_powerdown_i,
	input wire logic lownoise_amp_powerdown_i,
	input wire logic synth_lock_i,
	input wire logic [2:0] obs_o
);
	logic wr_pend;
	logic [1:0] wr_ch;
	logic [2:0][6:0] sh;
	logic [2:0] dir_known;
	logic [2:0] dir_val;
	logic rd_take;
	logic wr_take;
	logic [29:0] idx;
	assign idx = haddr_i[31:2];
	assign rd_take = hsel_i && hready_i && htrans_i[1] && !hwrite_i && hsize_i == 3'h2;
	assign wr_take = hsel_i && hready_i && htrans_i[1] && hwrite_i && hsize_i == 3'h2;
	////////////////////////////////////////////////////////////////////////////////
	// Shadow of the three control registers, built from bus traffic alone
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_pend <= 1'b0;
			wr_ch <= 2'h0;
		end else if (hready_i) begin
			wr_pend <= wr_take && idx >= rom_pkg::IDX_OBS_CTRL0 && idx <= rom_pkg::IDX_OBS_CTRL2;
			wr_ch <= 2'(idx - rom_pkg::IDX_OBS_CTRL0);
		end
	end
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sh <= 21'h0;
		end else if (wr_pend && hready_i) begin
			sh[wr_ch] <= hwdata_i[6:0];
		end
	end
	// Flopped sources are left unknown here; delimiter, strength and lock flags get their own properties below
	always_comb begin
		for (int c = 0; c < 3; c++) begin
			dir_known[c] = 1'b1;
			dir_val[c] = 1'b0;
			case (sh[c][5:0])
				rom_pkg::SEL_ONE: dir_val[c] = 1'b1;
				rom_pkg::SEL_TX_STATE: dir_val[c] = ffctrl_state_i >= rom_pkg::FF_TX_LO
					&& ffctrl_state_i <= rom_pkg::FF_TX_HI;
				rom_pkg::SEL_RX_STATE: dir_val[c] = ffctrl_state_i >= rom_pkg::FF_RX_LO
					&& ffctrl_state_i <= rom_pkg::FF_RX_HI;
				rom_pkg::SEL_RXQ_NONEMPTY: dir_val[c] = receive_queue_count_i != '0
					&& !receive_queue_overflow_i;
				rom_pkg::SEL_RXQ_LEVEL: begin
					dir_known[c] = receive_queue_overflow_i || receive_queue_frame_i;
					dir_val[c] = 1'b1;
				end
				rom_pkg::SEL_PKT_DONE: dir_val[c] = packet_done_i;
				rom_pkg::SEL_AMP_PD: dir_val[c] = amp_powerdown_i;
				rom_pkg::SEL_LNA_PD: dir_val[c] = lownoise_amp_powerdown_i;
				rom_pkg::SEL_SNIFF_DATA, rom_pkg::SEL_SNIFF_CLK, rom_pkg::SEL_RSSI_VALID,
				rom_pkg::SEL_SFD_SYNC, rom_pkg::SEL_RAND_XOR, rom_pkg::SEL_RAND_Q,
				rom_pkg::SEL_RAND_I, rom_pkg::SEL_LOCK: dir_known[c] = 1'b0;
				default: dir_val[c] = 1'b0;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);
	sequence rd_answer;
		!hreadyout_o ##1 hreadyout_o;
	endsequence
	sequence sfd_event;
		sh[1][5:0] == rom_pkg::SEL_SFD_SYNC && radio_rx_on_i && sfd_seen_i;
	endsequence
	sequence sfd_idle;
		sh[1][5:0] == rom_pkg::SEL_SFD_SYNC && !radio_rx_on_i && !radio_tx_on_i;
	endsequence
	sequence lock_held;
		(sh[0][5:0] == rom_pkg::SEL_LOCK && $stable(sh[0]) && $stable(synth_lock_i)) [*4];
	endsequence
	AST_RESP_OKAY: assert property (hresp_o == 1'b0)
		else $error("error response seen");
	AST_WR_NOWAIT: assert property (wr_take |=> hreadyout_o)
		else $error("write data phase stalled");
	AST_RD_WAIT: assert property (rd_take |=> rd_answer)
		else $error("read answer timing wrong");
	AST_RD_CTRL1: assert property (rd_take && idx == rom_pkg::IDX_OBS_CTRL1 |=>
		!hreadyout_o ##1 (hreadyout_o && hrdata_o == {25'h0, sh[1]}))
		else $error("control 1 read data wrong");
	for (genvar c = 0; c < 3; c++) begin : g_chan
		AST_DIRECT_PATH: assert property (dir_known[c] |->
			obs_o[c] == (dir_val[c] ^ sh[c][6]))
			else $error("observation output wrong for direct source");
	end
	AST_SFD_SET: assert property (sfd_event ##1 $stable(sh[1]) |-> obs_o[1] == !sh[1][6])
		else $error("delimiter flag not set");
	AST_SFD_CLR: assert property (sfd_idle ##1 $stable(sh[1]) |-> obs_o[1] == sh[1][6])
		else $error("delimiter flag not cleared");
	AST_RSSI_CLR: assert property ((sh[2][5:0] == rom_pkg::SEL_RSSI_VALID &&
		!radio_rx_on_i) ##1 $stable(sh[2]) |-> obs_o[2] == sh[2][6])
		else $error("strength flag not cleared");
	AST_LOCK_FOLLOW: assert property (lock_held |-> obs_o[0] == (synth_lock_i ^ sh[0][6]))
		else $error("lock output does not follow");
endmodule : rom_top_asserts
bind rom_top rom_top_asserts #(.RXQ_COUNT_W(RXQ_COUNT_W)) u_asserts (.core_clk_i, .resetn_i,
	.hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hreadyout_o,
	.hresp_o, .hrdata_o, .radio_rx_on_i, .radio_tx_on_i, .sfd_seen_i, .ffctrl_state_i,
	.receive_queue_count_i, .receive_queue_overflow_i, .receive_queue_frame_i,
	.packet_done_i, .amp_powerdown_i, .lownoise_amp_powerdown_i, .synth_lock_i, .obs_o);
`default_nettype wire

// [rom_obs_probe.sv]
// Test equipment model: counts rising edges on the observation pins
`timescale 1ns/1ns
`default_nettype none
module rom_obs_probe (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [2:0] obs_i,
	output logic [2:0][15:0] rise_count_o
);
	logic [2:0] last_reg;
	// Sampled on the core clock, so pulses shorter than a cycle go unseen
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			last_reg <= 3'h0;
			rise_count_o <= 48'h0;
		end else begin
			last_reg <= obs_i;
			for (int c = 0; c < 3; c++) begin
				if (obs_i[c] && !last_reg[c]) begin
					rise_count_o[c] <= rise_count_o[c] + 16'h1;
				end
			end
		end
	end
endmodule : rom_obs_probe
`default_nettype wire

// [radio_observation_mux_tb_top.sv]
// Self-checking bench for the radio observation multiplexer
`timescale 1ns/1ns
`default_nettype none
module radio_observation_mux_tb_top;
	logic core_clk_i, resetn_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
	logic [31:0] haddr_i, hwdata_i, hrdata_o;
	logic [1:0] htrans_i;
	logic [2:0] hsize_i, obs_o;
	logic radio_rx_on_i, radio_tx_on_i, sfd_seen_i, rssi_update_i, packet_done_i;
	logic receive_queue_overflow_i, receive_queue_frame_i, rand_i_i, rand_q_i;
	logic sniff_data_i, amp_powerdown_i, lownoise_amp_powerdown_i, synth_lock_i;
	logic [3:0] ffctrl_state_i;
	logic [7:0] receive_queue_count_i;
	logic [2:0][15:0] rises;
	int fail_count, check_count, cyc;
	rom_top #(.RXQ_COUNT_W(8)) dut_u (.core_clk_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i,
		.hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o, .hresp_o,
		.hrdata_o, .radio_rx_on_i, .radio_tx_on_i, .sfd_seen_i, .rssi_update_i,
		.ffctrl_state_i, .receive_queue_count_i, .receive_queue_overflow_i,
		.receive_queue_frame_i, .packet_done_i, .rand_i_i, .rand_q_i, .sniff_data_i,
		.amp_powerdown_i, .lownoise_amp_powerdown_i, .synth_lock_i, .obs_o);
	rom_obs_probe probe_u (.clk_i(core_clk_i), .resetn_i, .obs_i(obs_o), .rise_count_o(rises));
	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic step(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask : step
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask : chk
	// Master holds each phase until hready is sampled high
	task automatic bus(input logic wr, input logic [29:0] idx, input logic [7:0] wd,
		output logic [31:0] rd);
		@(posedge core_clk_i);
		hsel_i <= 1'b1;
		haddr_i <= {idx, 2'h0};
		htrans_i <= 2'h2;
		hwrite_i <= wr;
		do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= {24'h0, wd};
		do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
		rd = hrdata_o;
	endtask : bus
	task automatic wr(input logic [29:0] idx, input logic [7:0] d);
		logic [31:0] x;
		bus(1'b1, idx, d, x);
	endtask : wr
	task automatic rd_chk(input logic [29:0] idx, input logic [31:0] exp);
		logic [31:0] v;
		bus(1'b0, idx, 8'h00, v);
		chk("register read", exp, v);
	endtask : rd_chk
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_regs;
		rd_chk(rom_pkg::IDX_OBS_CTRL0, 32'h0);
		rd_chk(rom_pkg::IDX_OBS_CTRL1, 32'h0);
		rd_chk(rom_pkg::IDX_OBS_CTRL2, 32'h0);
		chk("obs after reset", 32'h0, 32'(obs_o));
		wr(rom_pkg::IDX_OBS_CTRL1, 8'hFF);
		rd_chk(rom_pkg::IDX_OBS_CTRL1, 32'h7F);
		wr(rom_pkg::IDX_OBS_CTRL2, 8'hC5);
		rd_chk(rom_pkg::IDX_OBS_CTRL2, 32'h45);
		rd_chk(rom_pkg::IDX_OBS_STATUS, 32'h06);
		wr(rom_pkg::IDX_RXQ_THRESH, 8'h33);
		rd_chk(rom_pkg::IDX_RXQ_THRESH, 32'h33);
		wr(rom_pkg::IDX_RXQ_THRESH, 8'h00);
		wr(30'h0000_6100, 8'h55);
		rd_chk(30'h0000_6100, 32'h0);
		$display("test_regs done");
	endtask : test_regs
	task automatic test_codes;
		logic [5:0] code [11] = '{rom_pkg::SEL_ZERO, rom_pkg::SEL_ONE, rom_pkg::SEL_TX_STATE,
			rom_pkg::SEL_RX_STATE, rom_pkg::SEL_RXQ_NONEMPTY, rom_pkg::SEL_RXQ_LEVEL,
			rom_pkg::SEL_PKT_DONE, rom_pkg::SEL_AMP_PD, rom_pkg::SEL_LNA_PD, 6'h3F, 6'h15};
		logic [10:0] e;
		for (int p = 0; p < 2; p++) begin
			@(posedge core_clk_i);
			ffctrl_state_i <= (p == 0) ? 4'hB : 4'h2;
			amp_powerdown_i <= (p == 0);
			lownoise_amp_powerdown_i <= (p == 1);
			packet_done_i <= (p == 0);
			receive_queue_count_i <= (p == 0) ? 8'h05 : 8'h00;
			receive_queue_overflow_i <= (p == 1);
			receive_queue_frame_i <= (p == 1);
			e = (p == 0) ? 11'h0F6 : 11'h12A;
			for (int c = 0; c < 3; c++) begin
				for (int i = 0; i < 2; i++) begin
					for (int k = 0; k < 11; k++) begin
						wr(rom_pkg::IDX_OBS_CTRL0 + 30'(c), {1'b0, i[0], code[k]});
						step(1);
						chk("obs code", 32'(e[k] ^ i[0]), 32'(obs_o[c]));
					end
				end
			end
		end
		$display("test_codes done");
	endtask : test_codes
	task automatic test_flags;
		wr(rom_pkg::IDX_OBS_CTRL1, {2'h0, rom_pkg::SEL_SFD_SYNC});
		wr(rom_pkg::IDX_OBS_CTRL2, {2'h1, rom_pkg::SEL_RSSI_VALID});
		@(posedge core_clk_i);
		radio_rx_on_i <= 1'b1;
		step(3);
		chk("sfd idle", 32'h0, 32'(obs_o[1]));
		chk("rssi idle", 32'h1, 32'(obs_o[2]));
		sfd_seen_i <= 1'b1;
		rssi_update_i <= 1'b1;
		@(posedge core_clk_i);
		sfd_seen_i <= 1'b0;
		rssi_update_i <= 1'b0;
		step(2);
		chk("sfd set", 32'h1, 32'(obs_o[1]));
		chk("rssi set", 32'h0, 32'(obs_o[2]));
		radio_rx_on_i <= 1'b0;
		radio_tx_on_i <= 1'b1;
		step(2);
		chk("sfd cleared", 32'h0, 32'(obs_o[1]));
		chk("rssi cleared", 32'h1, 32'(obs_o[2]));
		sfd_seen_i <= 1'b1;
		@(posedge core_clk_i);
		sfd_seen_i <= 1'b0;
		step(2);
		chk("sfd set in transmit", 32'h1, 32'(obs_o[1]));
		radio_tx_on_i <= 1'b0;
		step(2);
		chk("sfd cleared after transmit", 32'h0, 32'(obs_o[1]));
		$display("test_flags done");
	endtask : test_flags
	task automatic test_lock_rand;
		wr(rom_pkg::IDX_OBS_CTRL0, {2'h0, rom_pkg::SEL_LOCK});
		synth_lock_i <= 1'b1;
		step(5);
		chk("lock high", 32'h1, 32'(obs_o[0]));
		synth_lock_i <= 1'b0;
		step(5);
		chk("lock low", 32'h0, 32'(obs_o[0]));
		wr(rom_pkg::IDX_OBS_CTRL0, {2'h0, rom_pkg::SEL_RAND_XOR});
		wr(rom_pkg::IDX_OBS_CTRL1, {2'h0, rom_pkg::SEL_RAND_Q});
		wr(rom_pkg::IDX_OBS_CTRL2, {2'h0, rom_pkg::SEL_RAND_I});
		rand_i_i <= 1'b1;
		rand_q_i <= 1'b0;
		step(rom_pkg::RAND_UPDATE_CYC + 2);
		chk("random bits", 32'h5, 32'(obs_o));
		rand_q_i <= 1'b1;
		step(rom_pkg::RAND_UPDATE_CYC + 2);
		chk("random bits", 32'h6, 32'(obs_o));
		$display("test_lock_rand done");
	endtask : test_lock_rand
	task automatic test_sniff;
		logic [15:0] r0;
		wr(rom_pkg::IDX_OBS_CTRL1, {2'h0, rom_pkg::SEL_SNIFF_CLK});
		wr(rom_pkg::IDX_OBS_CTRL2, {2'h1, rom_pkg::SEL_SNIFF_DATA});
		sniff_data_i <= 1'b1;
		// Let the probe settle on the new source so the old one cannot mask an edge
		step(2);
		r0 = rises[1];
		step(8 * rom_pkg::SNIFF_HALF_CYC);
		chk("sniffer clock edges", 32'h4, 32'(rises[1] - r0));
		chk("sniffer data", 32'h0, 32'(obs_o[2]));
		$display("test_sniff done");
	endtask : test_sniff
	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report
	// Ceiling well above the roughly 4700 cycles the tests take
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			final_report();
		end
	end
	initial begin
		{resetn_i, hsel_i, hwrite_i, radio_rx_on_i, radio_tx_on_i, sfd_seen_i} = 6'h00;
		{rssi_update_i, packet_done_i, receive_queue_overflow_i, rand_i_i, rand_q_i} = 5'h00;
		{receive_queue_frame_i, sniff_data_i, amp_powerdown_i} = 3'h0;
		{lownoise_amp_powerdown_i, synth_lock_i} = 2'h0;
		haddr_i = 32'h0;
		hwdata_i = 32'h0;
		htrans_i = 2'h0;
		hsize_i = 3'h2;
		ffctrl_state_i = 4'h0;
		receive_queue_count_i = 8'h00;
		step(5);
		resetn_i <= 1'b1;
		test_regs();
		test_codes();
		test_flags();
		test_lock_rand();
		test_sniff();
		final_report();
	end
endmodule : radio_observation_mux_tb_top
`default_nettype wire
